// file: core/sep_params.svh
// Constants of the two-wire serial memory front end
`ifndef SEP_PARAMS_SVH
`define SEP_PARAMS_SVH

// ----------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------
`define SEP_CLK_NS 10
`define SEP_FILT_NS 100
`define SEP_FILT_CYC ((`SEP_FILT_NS + `SEP_CLK_NS - 1) / `SEP_CLK_NS)
`define SEP_WR_MS 5
`define SEP_WR_CYC (`SEP_WR_MS * 1000000 / `SEP_CLK_NS)

// ----------------------------------------------------------------
// Array and addressing
// ----------------------------------------------------------------
`define SEP_AW 13
`define SEP_DW 8
`define SEP_WORDS 8192
`define SEP_PAGE_BITS 5
`define SEP_DEV_CODE 4'ha
`define SEP_HI_BITS 5

// ----------------------------------------------------------------
// Buffering and reset values
// ----------------------------------------------------------------
`define SEP_FIFO_DEPTH 16
`define SEP_SYNC_RST 6'h03

`endif

// file: core/sep_pkg.sv
// Types of the two-wire serial memory front end
package sep_pkg;

	// ----------------------------------------------------------------
	// Transfer states
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_DEV,
		ST_ADDRH,
		ST_ADDRL,
		ST_WDATA,
		ST_RDATA,
		ST_RACK,
		ST_WAIT
	} sep_state_t;

endpackage

// file: core/sep_fifo.sv
// Parameterised first-in first-out buffer
`timescale 1ns/100ps
module sep_fifo #(
	parameter int WIDTH = 21,
	parameter int DEPTH = 16
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);

	localparam int PW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_r [0:DEPTH-1];
	logic [PW-1:0] wptr_r;
	logic [PW-1:0] rptr_r;
	logic [PW:0] count_r;
	wire push = in_valid_i && in_ready_o;
	wire pop = out_valid_o && out_ready_i;

	// ----------------------------------------------------------------
	// Flags
	// ----------------------------------------------------------------
	assign in_ready_o = (count_r != (PW+1)'(DEPTH));
	assign out_valid_o = (count_r != '0);
	assign out_data_o = mem_r[rptr_r];

	// ----------------------------------------------------------------
	// Storage and pointers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (push) begin
			mem_r[wptr_r] <= in_data_i;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			wptr_r <= '0;
			rptr_r <= '0;
			count_r <= '0;
		end else begin
			if (push) begin
				wptr_r <= wptr_r + 1'b1;
			end
			if (pop) begin
				rptr_r <= rptr_r + 1'b1;
			end
			count_r <= count_r + (PW+1)'(push) - (PW+1)'(pop);
		end
	end

endmodule // sep_fifo

// file: core/sep_slave.sv
// Two-wire serial memory slave with array and write timer
`timescale 1ns/100ps
`include "sep_params.svh"
module sep_slave #(
	parameter int WR_CYC = `SEP_WR_CYC
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_n_o,
	input wire logic chip_select_bit0_i,
	input wire logic chip_select_bit1_i,
	input wire logic chip_select_bit2_i,
	input wire logic wp_i,
	output logic write_busy_o
);
	import sep_pkg::*;

	localparam logic [3:0] FILT_CYC = 4'(`SEP_FILT_CYC);
	localparam logic [19:0] WR_LAST = 20'(WR_CYC - 1);
	localparam int FW = `SEP_AW + `SEP_DW;

	// ----------------------------------------------------------------
	// Functions
	// ----------------------------------------------------------------
	// Returns {level, count} of a line filter
	function automatic logic [4:0] filt_step(input logic raw,
		input logic cur, input logic [3:0] cnt);
		if (raw == cur) begin
			filt_step = {cur, 4'h0};
		end else if (cnt == FILT_CYC - 4'h1) begin
			filt_step = {raw, 4'h0};
		end else begin
			filt_step = {cur, 4'(cnt + 4'h1)};
		end
	endfunction

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic [5:0] sync1_r;
	logic [5:0] sync2_r;
	logic scl_f_r;
	logic sda_f_r;
	logic [3:0] scl_cnt_r;
	logic [3:0] sda_cnt_r;
	logic scl_prev_r;
	logic sda_prev_r;
	sep_state_t state_r;
	sep_state_t state_nxt;
	logic [3:0] bit_r;
	logic [3:0] bit_nxt;
	logic [7:0] shr_r;
	logic [7:0] shr_nxt;
	logic [7:0] tx_r;
	logic [7:0] tx_nxt;
	logic [`SEP_AW-1:0] ptr_r;
	logic [`SEP_AW-1:0] ptr_nxt;
	logic oe_n_r;
	logic oe_n_nxt;
	logic wrote_r;
	logic wrote_nxt;
	logic push;
	logic rd_req;
	logic start_wr;
	logic busy_r;
	logic [19:0] busy_cnt_r;
	logic sda_o_r;
	logic [7:0] rdata_r;
	logic [`SEP_DW-1:0] mem_r [0:`SEP_WORDS-1];
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic [FW-1:0] fifo_out_data;

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	wire [5:0] pins = {chip_select_bit2_i, chip_select_bit1_i,
		chip_select_bit0_i, wp_i, sda_i, scl_i};
	wire scl_s = sync2_r[0];
	wire sda_s = sync2_r[1];
	wire wp_on = sync2_r[2];
	wire [2:0] sel_code = sync2_r[5:3];

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			sync1_r <= `SEP_SYNC_RST;
			sync2_r <= `SEP_SYNC_RST;
		end else begin
			sync1_r <= pins;
			sync2_r <= sync1_r;
		end
	end

	// ----------------------------------------------------------------
	// Glitch filters
	// ----------------------------------------------------------------
	wire [4:0] scl_step = filt_step(scl_s, scl_f_r, scl_cnt_r);
	wire [4:0] sda_step = filt_step(sda_s, sda_f_r, sda_cnt_r);

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			scl_f_r <= 1'b1;
			sda_f_r <= 1'b1;
			scl_cnt_r <= 4'h0;
			sda_cnt_r <= 4'h0;
			scl_prev_r <= 1'b1;
			sda_prev_r <= 1'b1;
		end else begin
			scl_f_r <= scl_step[4];
			sda_f_r <= sda_step[4];
			scl_cnt_r <= scl_step[3:0];
			sda_cnt_r <= sda_step[3:0];
			scl_prev_r <= scl_f_r;
			sda_prev_r <= sda_f_r;
		end
	end

	// ----------------------------------------------------------------
	// Bus events
	// ----------------------------------------------------------------
	wire scl_rise = scl_f_r && !scl_prev_r;
	wire scl_fall = !scl_f_r && scl_prev_r;
	wire scl_high = scl_f_r && scl_prev_r;
	wire start_det = scl_high && sda_prev_r && !sda_f_r;
	wire stop_det = scl_high && !sda_prev_r && sda_f_r;
	wire dev_match = (shr_r[7:4] == `SEP_DEV_CODE) &&
		(shr_r[3:1] == sel_code);
	wire [`SEP_PAGE_BITS-1:0] page_inc =
		`SEP_PAGE_BITS'(ptr_r[`SEP_PAGE_BITS-1:0] + 1'b1);
	wire [`SEP_AW-1:0] ptr_page = {ptr_r[`SEP_AW-1:`SEP_PAGE_BITS],
		page_inc};
	wire rx_state = (state_r == ST_DEV) || (state_r == ST_ADDRH) ||
		(state_r == ST_ADDRL) || (state_r == ST_WDATA);
	wire fifo_out_ready = !rd_req;
	wire mem_we = fifo_out_valid && fifo_out_ready;

	// ----------------------------------------------------------------
	// Transfer engine
	// ----------------------------------------------------------------
	always_comb begin
		state_nxt = state_r;
		bit_nxt = bit_r;
		shr_nxt = shr_r;
		tx_nxt = tx_r;
		ptr_nxt = ptr_r;
		oe_n_nxt = oe_n_r;
		wrote_nxt = wrote_r;
		push = 1'b0;
		rd_req = 1'b0;
		start_wr = 1'b0;
		if (stop_det) begin
			state_nxt = ST_IDLE;
			oe_n_nxt = 1'b1;
			bit_nxt = 4'h0;
			start_wr = wrote_r;
			wrote_nxt = 1'b0;
		end else if (start_det) begin
			state_nxt = busy_r ? ST_IDLE : ST_DEV;
			oe_n_nxt = 1'b1;
			bit_nxt = 4'h0;
			wrote_nxt = 1'b0;
		end else if (rx_state) begin
			if (scl_rise && bit_r < 4'h8) begin
				shr_nxt = {shr_r[6:0], sda_f_r};
				bit_nxt = bit_r + 4'h1;
			end else if (scl_fall && bit_r == 4'h8) begin
				bit_nxt = 4'h9;
				case (state_r)
					ST_DEV: begin
						if (!dev_match) begin
							state_nxt = ST_IDLE;
						end else if (shr_r[0]) begin
							oe_n_nxt = 1'b0;
							rd_req = 1'b1;
							state_nxt = ST_RDATA;
						end else begin
							oe_n_nxt = 1'b0;
							state_nxt = ST_ADDRH;
						end
					end
					ST_ADDRH: begin
						ptr_nxt[`SEP_AW-1:8] = shr_r[`SEP_HI_BITS-1:0];
						oe_n_nxt = 1'b0;
						state_nxt = ST_ADDRL;
					end
					ST_ADDRL: begin
						ptr_nxt[7:0] = shr_r;
						oe_n_nxt = 1'b0;
						state_nxt = ST_WDATA;
					end
					ST_WDATA: begin
						if (fifo_in_ready) begin
							oe_n_nxt = 1'b0;
							push = !wp_on;
							wrote_nxt = wrote_r || !wp_on;
							ptr_nxt = ptr_page;
						end else begin
							state_nxt = ST_WAIT;
						end
					end
					default: begin
						state_nxt = ST_IDLE;
					end
				endcase
			end else if (scl_fall && bit_r == 4'h9) begin
				oe_n_nxt = 1'b1;
				bit_nxt = 4'h0;
			end
		end else begin
			case (state_r)
				ST_RDATA: begin
					if (scl_fall && bit_r == 4'h9) begin
						tx_nxt = rdata_r;
						oe_n_nxt = rdata_r[7];
						bit_nxt = 4'h1;
					end else if (scl_fall && bit_r < 4'h8) begin
						oe_n_nxt = tx_r[6];
						tx_nxt = {tx_r[6:0], 1'b0};
						bit_nxt = bit_r + 4'h1;
					end else if (scl_fall && bit_r == 4'h8) begin
						oe_n_nxt = 1'b1;
						ptr_nxt = ptr_r + 1'b1;
						bit_nxt = 4'h0;
						state_nxt = ST_RACK;
					end
				end
				ST_RACK: begin
					if (scl_rise && !sda_f_r) begin
						rd_req = 1'b1;
						bit_nxt = 4'h9;
						state_nxt = ST_RDATA;
					end else if (scl_rise) begin
						state_nxt = ST_WAIT;
					end
				end
				ST_IDLE: begin
					state_nxt = ST_IDLE;
				end
				ST_WAIT: begin
					state_nxt = ST_WAIT;
				end
				default: begin
					state_nxt = ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_r <= ST_IDLE;
			bit_r <= 4'h0;
			shr_r <= 8'h00;
			tx_r <= 8'h00;
			ptr_r <= '0;
			oe_n_r <= 1'b1;
			wrote_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			bit_r <= bit_nxt;
			shr_r <= shr_nxt;
			tx_r <= tx_nxt;
			ptr_r <= ptr_nxt;
			oe_n_r <= oe_n_nxt;
			wrote_r <= wrote_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Write cycle timer
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			busy_r <= 1'b0;
			busy_cnt_r <= 20'h00000;
		end else if (start_wr) begin
			busy_r <= 1'b1;
			busy_cnt_r <= WR_LAST;
		end else if (busy_cnt_r != 20'h00000) begin
			busy_cnt_r <= busy_cnt_r - 20'h00001;
		end else begin
			busy_r <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Write buffer and array
	// ----------------------------------------------------------------
	sep_fifo #(
		.WIDTH(FW),
		.DEPTH(`SEP_FIFO_DEPTH)
	) u_fifo (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.in_valid_i(push),
		.in_ready_o(fifo_in_ready),
		.in_data_i({ptr_r, shr_r}),
		.out_valid_o(fifo_out_valid),
		.out_ready_i(fifo_out_ready),
		.out_data_o(fifo_out_data)
	);

	always_ff @(posedge clk_i) begin
		if (mem_we) begin
			mem_r[fifo_out_data[FW-1:`SEP_DW]] <=
				fifo_out_data[`SEP_DW-1:0];
		end
		if (rd_req) begin
			rdata_r <= mem_r[ptr_r];
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			sda_o_r <= 1'b0;
		end else begin
			sda_o_r <= 1'b0;
		end
	end

	assign sda_o = sda_o_r;
	assign sda_oe_n_o = oe_n_r;
	assign write_busy_o = busy_r;

endmodule // sep_slave

// file: sim/sep_slave_checker.sv
// Port assertions of the two-wire serial memory slave
`timescale 1ns/100ps
module sep_slave_checker #(
	parameter int WR_CYC = 500000
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic scl_i,
	input wire logic sda_i,
	input wire logic sda_o,
	input wire logic sda_oe_n_o,
	input wire logic chip_select_bit0_i,
	input wire logic chip_select_bit1_i,
	input wire logic chip_select_bit2_i,
	input wire logic wp_i,
	input wire logic write_busy_o
);
	int busy_cnt_r;
	logic [5:0] since_stop_r;
	logic sda_d_r;
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			busy_cnt_r <= 0;
			since_stop_r <= 6'h3f;
			sda_d_r <= 1'b1;
		end else begin
			sda_d_r <= sda_i;
			busy_cnt_r <= write_busy_o ? busy_cnt_r + 1 : 0;
			if (scl_i && sda_i && !sda_d_r)
				since_stop_r <= 6'h00;
			else if (since_stop_r != 6'h3f)
				since_stop_r <= since_stop_r + 6'h01;
		end
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	chk_drive_low_only: assert property (!sda_oe_n_o |-> !sda_o)
		else $error("data pin driven high");
	chk_drive_on_fall: assert property ($changed(sda_oe_n_o) |->
		!scl_i && !$past(scl_i, 8)) else $error("drive change not in low");
	chk_ack_holds: assert property ($fell(sda_oe_n_o) |=>
		!sda_oe_n_o [*8]) else $error("drive pulse too short");
	chk_busy_quiet: assert property (write_busy_o |-> sda_oe_n_o)
		else $error("drive during write cycle");
	chk_busy_length: assert property ($fell(write_busy_o) |->
		busy_cnt_r >= WR_CYC - 1 && busy_cnt_r <= WR_CYC + 1)
		else $error("write cycle length wrong");
	chk_busy_after_stop: assert property ($rose(write_busy_o) |->
		since_stop_r <= 6'h20) else $error("write cycle without stop");
	chk_wp_blocks: assert property ($rose(write_busy_o) |-> !wp_i)
		else $error("write cycle while protected");
	chk_busy_idle_bus: assert property ($rose(write_busy_o) |->
		scl_i && sda_i) else $error("write cycle on busy bus");
	cover property ($rose(write_busy_o));
	cover property ($fell(write_busy_o));
	cover property ($fell(sda_oe_n_o));
endmodule // sep_slave_checker

// file: sim/sep_master.sv
// Two-wire bus master model
`timescale 1ns/100ps
module sep_master (
	input wire logic clk_i,
	input wire logic sda_i,
	output logic scl_o,
	output logic sda_pull_o
);
	initial begin
		scl_o = 1'b1;
		sda_pull_o = 1'b0;
	end
	task automatic hp(input int n);
		repeat (n) @(negedge clk_i);
	endtask
	task automatic start();
		hp(13);
		sda_pull_o = 1'b0;
		hp(13);
		scl_o = 1'b1;
		hp(26);
		sda_pull_o = 1'b1;
		hp(26);
		scl_o = 1'b0;
	endtask
	task automatic stop();
		hp(13);
		sda_pull_o = 1'b1;
		hp(13);
		scl_o = 1'b1;
		hp(26);
		sda_pull_o = 1'b0;
		hp(26);
	endtask
	task automatic bitx(input logic b, output logic r);
		hp(13);
		sda_pull_o = !b;
		hp(13);
		scl_o = 1'b1;
		hp(13);
		r = sda_i;
		hp(13);
		scl_o = 1'b0;
	endtask
	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bitx(d[i], r);
		bitx(1'b1, r);
		ack = !r;
	endtask
	task automatic rbyte(input logic mack, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bitx(1'b1, r);
			d[i] = r;
		end
		bitx(!mack, r);
	endtask
	task automatic glitch();
		hp(13);
		scl_o = 1'b1;
		hp(5);
		scl_o = 1'b0;
	endtask
endmodule // sep_master

// file: sim/sep_slave_bench.sv
// Self-checking bench of the two-wire serial memory slave
`timescale 1ns/100ps
module sep_slave_bench;
	localparam int WR_CYC = 2000;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic scl, sda_pull, sda_oe_n, sda_o_w, busy, sda;
	logic [2:0] sel = 3'b101;
	logic wp = 1'b0;
	logic [7:0] dev_w;
	int failures = 0;
	int tests_run = 0;
	assign sda = !sda_pull && (sda_oe_n || sda_o_w);
	assign dev_w = {4'ha, sel, 1'b0};
	always #5 clk_i = ~clk_i;
	sep_slave #(.WR_CYC(WR_CYC)) i_sep_slave (.clk_i(clk_i), .rst_i(rst_i),
		.scl_i(scl), .sda_i(sda), .sda_o(sda_o_w), .sda_oe_n_o(sda_oe_n),
		.chip_select_bit0_i(sel[0]), .chip_select_bit1_i(sel[1]),
		.chip_select_bit2_i(sel[2]), .wp_i(wp), .write_busy_o(busy));
	sep_master i_sep_master (.clk_i(clk_i), .sda_i(sda), .scl_o(scl),
		.sda_pull_o(sda_pull));
	task automatic check(input string nm, input logic [7:0] seen, exp);
		tests_run++;
		if (seen !== exp) begin
			failures++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic stop_test();
		if (failures == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic put(input logic [7:0] d, input logic e);
		logic a;
		i_sep_master.wbyte(d, a);
		check("ack", {7'h0, a}, {7'h0, e});
	endtask
	task automatic wait_busy(input logic v, input int n);
		for (int i = 0; i < n && busy !== v; i++) @(negedge clk_i);
		check("busy", {7'h0, busy}, {7'h0, v});
	endtask
	task automatic set_ptr(input logic [12:0] ad);
		i_sep_master.start();
		put(dev_w, 1'b1);
		put({3'h0, ad[12:8]}, 1'b1);
		put(ad[7:0], 1'b1);
	endtask
	task automatic get2(input logic [12:0] ad, input logic [7:0] e0, e1);
		logic [7:0] d;
		set_ptr(ad);
		i_sep_master.start();
		put(dev_w | 8'h01, 1'b1);
		i_sep_master.rbyte(1'b1, d);
		check("rd0", d, e0);
		i_sep_master.rbyte(1'b0, d);
		check("rd1", d, e1);
		i_sep_master.stop();
	endtask
	task automatic t_fifo();
		logic a;
		set_ptr(13'h1f3c);
		for (int i = 0; i < 34; i++) begin
			i_sep_master.wbyte(8'h40 + i[7:0], a);
			check("page_ack", {7'h0, a}, 8'h01);
		end
		i_sep_master.stop();
		check("busy_page", {7'h0, busy}, 8'h01);
		wait_busy(1'b0, 3000);
		get2(13'h1f3c, 8'h60, 8'h61);
		get2(13'h1f20, 8'h44, 8'h45);
		get2(13'h1f3b, 8'h5f, 8'h60);
	endtask
	task automatic t_select();
		for (int i = 0; i < 9; i++) begin
			i_sep_master.start();
			if (i < 8)
				put({4'ha, i[2:0], 1'b0}, i[2:0] == sel);
			else
				put({4'hb, sel, 1'b0}, 1'b0);
			i_sep_master.stop();
		end
	endtask
	task automatic t_page_write();
		set_ptr(13'h0a3e);
		for (int i = 0; i < 4; i++) put(8'hc0 + i[7:0], 1'b1);
		i_sep_master.stop();
		wait_busy(1'b1, 40);
		i_sep_master.start();
		put(dev_w, 1'b0);
		i_sep_master.stop();
		wait_busy(1'b0, 3000);
		get2(13'h0a3e, 8'hc0, 8'hc1);
		get2(13'h0a20, 8'hc2, 8'hc3);
	endtask
	task automatic t_wp();
		wp = 1'b1;
		set_ptr(13'h0a3e);
		put(8'h77, 1'b1);
		i_sep_master.stop();
		repeat (40) @(negedge clk_i);
		check("busy_wp", {7'h0, busy}, 8'h00);
		get2(13'h0a3e, 8'hc0, 8'hc1);
		wp = 1'b0;
	endtask
	task automatic t_glitch_abort();
		logic r;
		logic [7:0] d;
		set_ptr(13'h0a3f);
		for (int i = 0; i < 4; i++) i_sep_master.bitx(1'b0, r);
		i_sep_master.start();
		i_sep_master.glitch();
		put(dev_w | 8'h01, 1'b1);
		i_sep_master.rbyte(1'b0, d);
		check("rd_abort", d, 8'hc1);
		i_sep_master.stop();
	endtask
	initial begin
		#800000;
		failures++;
		stop_test();
	end
	initial begin
		repeat (8) @(negedge clk_i);
		rst_i = 1'b0;
		repeat (30) @(negedge clk_i);
		t_fifo();
		t_select();
		sel = 3'b010;
		t_select();
		t_page_write();
		t_wp();
		t_glitch_abort();
		stop_test();
	end
endmodule // sep_slave_bench
bind sep_slave sep_slave_checker #(.WR_CYC(WR_CYC)) i_chk (.clk_i(clk_i),
	.rst_i(rst_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
	.sda_oe_n_o(sda_oe_n_o), .chip_select_bit0_i(chip_select_bit0_i),
	.chip_select_bit1_i(chip_select_bit1_i),
	.chip_select_bit2_i(chip_select_bit2_i), .wp_i(wp_i),
	.write_busy_o(write_busy_o));
